// file: hw/pbc_regs.svh
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

// ----------------------------------------------------------------------------
// Ring geometry
// ----------------------------------------------------------------------------
`define NUM_CELLS          5
`define CABLE_CELL         0
`define CDR_CELL           0
`define FIRST_DRIVE_CELL   1

// ----------------------------------------------------------------------------
// Clocks and reference
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      32'h0000_000A
`define REF_RATIO          5'h0A
`define REF_TOL_BITS       5'h01
`define REF_CNT_W          5
`define REF_CNT_MAX        5'h1F
`define FREQ_GOOD_PERIODS  4'h4
`define GOOD_CNT_W         4

// ----------------------------------------------------------------------------
// Phase acquisition on the incoming stream
// ----------------------------------------------------------------------------
`define PHASE_EDGES        4'h8
`define MAX_RUN_BITS       3'h5
`define RUN_CNT_W          3

// ----------------------------------------------------------------------------
// Amplitude detection, millivolts peak-to-peak
// ----------------------------------------------------------------------------
`define AMP_W              10
`define AMP_HIGH_MV        10'h190
`define AMP_LOW_MV         10'h064

// ----------------------------------------------------------------------------
// Elastic buffer behind the retimer
// ----------------------------------------------------------------------------
`define FIFO_DEPTH         4
`define FIFO_WIDTH         1
`define FIFO_LVL_W         3
`define FIFO_FILL_START    3'h2
`define IDLE_BIT           1'b0

`endif

// file: hw/pbc_pkg.sv
// ----------------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------------
`include "pbc_regs.svh"

package pbc_pkg;

  // Recovery loop states
  typedef enum logic [2:0] {
    CDR_FREQ_ACQ  = 3'b001,
    CDR_PHASE_ACQ = 3'b010,
    CDR_LOCKED    = 3'b100
  } cdr_state_t;

  // Pin levels sampled together in one synchroniser
  typedef struct packed {
    logic [`NUM_CELLS-1:0] drive;
    logic [`NUM_CELLS-1:0] skip_n;
  } pin_group_t;

  // Reference clock health as one bundle
  typedef struct packed {
    logic edge_seen;
    logic period_ok;
    logic lost;
  } ref_status_t;

endpackage : pbc_pkg

// file: hw/pbc_cell.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// One 2:1 selector cell of the ring
// ----------------------------------------------------------------------------
module pbc_cell (
  // Ring side
  input  wire logic upstream,
  output logic      forward,
  // Drive side
  input  wire logic skip_n,
  input  wire logic drive_in,
  output logic      drive_out
);

  // Drive always sees the ring; only the return path is selected
  assign drive_out = upstream;
  assign forward   = skip_n ? drive_in : upstream;

endmodule : pbc_cell

// file: hw/pbc_fifo.sv
`timescale 1ns/100ps
`include "pbc_regs.svh"
// ----------------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ----------------------------------------------------------------------------
module pbc_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int LVL_W = `FIFO_LVL_W
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             flush,
  // Fill side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // Drain side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data,
  // Occupancy
  output logic      [LVL_W-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [LVL_W-1:0] count_reg;
  logic             push;
  logic             pop;

  // Handshake decode; honest full and empty from the count
  assign wr_ready = (count_reg != LVL_W'(DEPTH));
  assign rd_valid = (count_reg != '0);
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;
  assign rd_data  = mem[rd_ptr_reg];
  assign level    = count_reg;

  // Storage, no reset needed on the data itself
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (push) wr_ptr_reg <= PTR_W'(wr_ptr_reg + 1'b1);
        if (pop)  rd_ptr_reg <= PTR_W'(rd_ptr_reg + 1'b1);
        count_reg <= LVL_W'(count_reg + LVL_W'(push) - LVL_W'(pop));
      end
    end
  end

endmodule : pbc_fifo

// file: hw/loop_port_bypass_retimer.sv
// Overview of operation
// - Five selector cells chained; each forwards its drive input or the upstream stream.
// - Each cell is either in-loop (drive used) or bypassed (drive skipped).
// - In-loop cell sends upstream stream to its drive and forwards the drive's return.
// - Low port_skip_n forwards upstream unchanged and ignores the drive input.
// - port_skip_n reads high when unconnected, selecting in-loop mode.
// - Cable on cell 0, drives on cells 1-4: retiming precedes the first drive.
// - Cable cell choice places the retimer relative to drives A to D.
// - Recovery acquires frequency from freq_ref_clock, then phase, repeatedly and automatically.
// - Lock needs no training input; locked recovery resamples the stream for its output.
// - amplitude_ok high above 400 mV, low below 100 mV, undefined between.
// - amplitude_ok tracks the cable only when the retimer precedes the first drive.
// - Device also serves as five pass-through buffers, one of them retimed.
`timescale 1ns/100ps
`include "pbc_regs.svh"

module loop_port_bypass_retimer
  import pbc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // Serial ring pins, one bit per line clock
  input  wire logic [`NUM_CELLS-1:0]  drive_in,
  output logic      [`NUM_CELLS-1:0]  drive_out,
  // Per-cell bypass straps, active low
  input  wire logic [`NUM_CELLS-1:0]  port_skip_n,
  // Recovery reference and status
  input  wire logic                   freq_ref_clock,
  output logic                        cdr_locked,
  // Amplitude detection on cell 0's drive input
  input  wire logic [`AMP_W-1:0]      amp_level_mv,
  output logic                        amplitude_ok
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  pin_group_t pins_raw;
  pin_group_t pins_meta_reg;
  pin_group_t pins_sync_reg;
  logic       ref_meta_reg;
  logic       ref_sync_reg;
  logic       ref_prev_reg;

  // Group the pins so they cross together
  assign pins_raw = '{drive: drive_in, skip_n: port_skip_n};

  // Skip straps come out of reset high, as an undriven pulled-up pin reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta_reg <= '{drive: '0, skip_n: '1};
      pins_sync_reg <= '{drive: '0, skip_n: '1};
    end else if (ce) begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // Reference clock sampled as a level, edge found after the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_meta_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
    end else if (ce) begin
      ref_meta_reg <= freq_ref_clock;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Selector ring
  // --------------------------------------------------------------------------
  logic [`NUM_CELLS-1:0] upstream;
  logic [`NUM_CELLS-1:0] forward;
  logic [`NUM_CELLS-1:0] cell_drive_out;
  logic                  line_after_cdr;

  // Each cell is the same selector; the retimed stream re-enters at cell 1.
  // The registered retimer is what breaks the otherwise closed ring.
  generate
    for (genvar i = 0; i < `NUM_CELLS; i++) begin : g_cell
      if (i == `CDR_CELL) begin : g_close
        assign upstream[i] = forward[`NUM_CELLS-1];
      end else if (i == `FIRST_DRIVE_CELL) begin : g_after_cdr
        assign upstream[i] = line_after_cdr;
      end else begin : g_chain
        assign upstream[i] = forward[i-1];
      end
      pbc_cell u_cell (
        .upstream  (upstream[i]),
        .forward   (forward[i]),
        .skip_n    (pins_sync_reg.skip_n[i]),
        .drive_in  (pins_sync_reg.drive[i]),
        .drive_out (cell_drive_out[i])
      );
    end
  endgenerate

  // Drive pins launched from flops, one register per line bit
  logic [`NUM_CELLS-1:0] drive_out_reg;

  // Any cell can double as a plain buffer; cell 0's path is the retimed one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_out_reg <= '0;
    end else if (ce) begin
      drive_out_reg <= cell_drive_out;
    end
  end

  assign drive_out = drive_out_reg;

  // --------------------------------------------------------------------------
  // Reference frequency check
  // --------------------------------------------------------------------------
  logic [`REF_CNT_W-1:0]  ref_cnt_reg;
  logic [`REF_CNT_W-1:0]  ref_cnt_next;
  logic [`GOOD_CNT_W-1:0] freq_good_reg;
  ref_status_t            ref_status;
  logic                   ref_rise;
  logic [`REF_CNT_W-1:0]  ref_period;

  // A ref period of ten line bits, give or take one, counts as on frequency
  assign ref_rise     = ref_sync_reg & ~ref_prev_reg;
  assign ref_period   = `REF_CNT_W'(ref_cnt_reg + 1'b1);
  assign ref_cnt_next = ref_rise ? '0 :
                        (ref_cnt_reg == `REF_CNT_MAX) ? ref_cnt_reg : `REF_CNT_W'(ref_cnt_reg + 1'b1);
  assign ref_status.edge_seen = ref_rise;
  assign ref_status.period_ok = (ref_period >= `REF_CNT_W'(`REF_RATIO - `REF_TOL_BITS)) &&
                                (ref_period <= `REF_CNT_W'(`REF_RATIO + `REF_TOL_BITS));
  assign ref_status.lost      = (ref_cnt_reg == `REF_CNT_MAX);

  // Period counter and run of good periods
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_reg   <= '0;
      freq_good_reg <= '0;
    end else if (ce) begin
      ref_cnt_reg <= ref_cnt_next;
      if (ref_status.lost) begin
        freq_good_reg <= '0;
      end else if (ref_status.edge_seen) begin
        if (!ref_status.period_ok) begin
          freq_good_reg <= '0;
        end else if (freq_good_reg != `FREQ_GOOD_PERIODS) begin
          freq_good_reg <= `GOOD_CNT_W'(freq_good_reg + 1'b1);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Incoming stream activity at the retimer input
  // --------------------------------------------------------------------------
  logic                   cdr_in_prev_reg;
  logic [`RUN_CNT_W-1:0]  run_len_reg;
  logic                   data_edge;
  logic                   run_too_long;

  // 8b/10b never holds a level longer than five bits; a run of seven bits or more is taken as no data
  assign data_edge    = forward[`CDR_CELL] ^ cdr_in_prev_reg;
  assign run_too_long = (run_len_reg >= `MAX_RUN_BITS) & ~data_edge;

  // Run length since the last transition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdr_in_prev_reg <= 1'b0;
      run_len_reg     <= '0;
    end else if (ce) begin
      cdr_in_prev_reg <= forward[`CDR_CELL];
      if (data_edge) begin
        run_len_reg <= '0;
      end else if (run_len_reg != `MAX_RUN_BITS) begin
        run_len_reg <= `RUN_CNT_W'(run_len_reg + 1'b1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Recovery loop state machine
  // --------------------------------------------------------------------------
  cdr_state_t             cdr_state_reg;
  cdr_state_t             cdr_state_next;
  logic [`GOOD_CNT_W-1:0] edge_cnt_reg;
  logic                   freq_locked;
  logic                   freq_fault;
  logic                   phase_locked;
  logic                   lock_drop;

  // Lock is earned purely from ref and data; nothing outside trains it
  assign freq_locked  = (freq_good_reg == `FREQ_GOOD_PERIODS);
  assign freq_fault   = ref_status.lost | (ref_status.edge_seen & ~ref_status.period_ok);
  assign phase_locked = (edge_cnt_reg == `PHASE_EDGES) & data_edge;
  assign lock_drop    = (cdr_state_reg != CDR_FREQ_ACQ) & (freq_fault | run_too_long);

  // Frequency first, then phase; a reference fault, or a long run once locked, falls back and starts over
  always_comb begin
    cdr_state_next = cdr_state_reg;
    case (cdr_state_reg)
      CDR_FREQ_ACQ: begin
        if (freq_locked && !freq_fault) cdr_state_next = CDR_PHASE_ACQ;
      end
      CDR_PHASE_ACQ: begin
        if (freq_fault)        cdr_state_next = CDR_FREQ_ACQ;
        else if (phase_locked) cdr_state_next = CDR_LOCKED;
      end
      CDR_LOCKED: begin
        if (freq_fault || run_too_long) cdr_state_next = CDR_FREQ_ACQ;
      end
      default: begin
        cdr_state_next = CDR_FREQ_ACQ;
      end
    endcase
  end

  // State and edge count during phase acquisition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdr_state_reg <= CDR_FREQ_ACQ;
      edge_cnt_reg  <= '0;
    end else if (ce) begin
      cdr_state_reg <= cdr_state_next;
      if (cdr_state_reg != CDR_PHASE_ACQ || run_too_long) begin
        edge_cnt_reg <= '0;
      end else if (data_edge && edge_cnt_reg != `PHASE_EDGES) begin
        edge_cnt_reg <= `GOOD_CNT_W'(edge_cnt_reg + 1'b1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Retimer and elastic buffer
  // --------------------------------------------------------------------------
  logic                   sample_tick;
  logic                   retime_bit_reg;
  logic                   retime_valid_reg;
  logic                   fifo_wr_ready;
  logic                   fifo_rd_valid;
  logic                   fifo_rd_ready;
  logic [`FIFO_WIDTH-1:0] fifo_rd_data;
  logic [`FIFO_LVL_W-1:0] fifo_level;
  logic                   fill_hold_reg;
  logic                   cdr_locked_reg;

  // Recovered clock is one sample per line bit once bit-locked
  assign sample_tick   = (cdr_state_reg == CDR_LOCKED);
  assign fifo_rd_ready = cdr_locked_reg & ~fill_hold_reg;
  assign line_after_cdr = (fifo_rd_valid & fifo_rd_ready) ? fifo_rd_data[0] : `IDLE_BIT;

  // Single sample stage; it holds its bit while the buffer is full
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      retime_bit_reg   <= 1'b0;
      retime_valid_reg <= 1'b0;
    end else if (ce) begin
      if (lock_drop) begin
        retime_valid_reg <= 1'b0;
      end else if (sample_tick && (!retime_valid_reg || fifo_wr_ready)) begin
        retime_bit_reg   <= forward[`CDR_CELL];
        retime_valid_reg <= 1'b1;
      end else if (fifo_wr_ready) begin
        retime_valid_reg <= 1'b0;
      end
    end
  end

  // Drain waits until the buffer is half full after each new lock, for slip room
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_hold_reg  <= 1'b1;
      cdr_locked_reg <= 1'b0;
    end else if (ce) begin
      cdr_locked_reg <= (cdr_state_next == CDR_LOCKED);
      if (cdr_state_next != CDR_LOCKED) begin
        fill_hold_reg <= 1'b1;
      end else if (fifo_level >= `FIFO_FILL_START) begin
        fill_hold_reg <= 1'b0;
      end
    end
  end

  assign cdr_locked = cdr_locked_reg;

  // Four-entry elastic buffer between sampler and ring
  pbc_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .LVL_W (`FIFO_LVL_W)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .flush    (lock_drop),
    .wr_valid (retime_valid_reg),
    .wr_ready (fifo_wr_ready),
    .wr_data  (retime_bit_reg),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data),
    .level    (fifo_level)
  );

  // --------------------------------------------------------------------------
  // Amplitude detection
  // --------------------------------------------------------------------------
  logic [`AMP_W-1:0] amp_meta_reg;
  logic [`AMP_W-1:0] amp_sync_reg;
  logic [`AMP_W-1:0] amp_prev_reg;
  logic              amp_stable;
  logic              amp_high;
  logic              amp_low;
  logic              amplitude_ok_reg;

  // Multi-bit level: only trusted when two synced samples agree
  assign amp_stable = (amp_sync_reg == amp_prev_reg);
  assign amp_high   = amp_stable & (amp_sync_reg >= `AMP_HIGH_MV);
  assign amp_low    = amp_stable & (amp_sync_reg <= `AMP_LOW_MV);

  // Level synchroniser and stability sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_meta_reg <= '0;
      amp_sync_reg <= '0;
      amp_prev_reg <= '0;
    end else if (ce) begin
      amp_meta_reg <= amp_level_mv;
      amp_sync_reg <= amp_meta_reg;
      amp_prev_reg <= amp_sync_reg;
    end
  end

  // Between the thresholds the flag simply keeps its last value.
  // It watches cell 0's input, which is the cable only with the cable on cell 0.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amplitude_ok_reg <= 1'b0;
    end else if (ce) begin
      if (amp_high) begin
        amplitude_ok_reg <= 1'b1;
      end else if (amp_low) begin
        amplitude_ok_reg <= 1'b0;
      end
    end
  end

  assign amplitude_ok = amplitude_ok_reg;

endmodule : loop_port_bypass_retimer

// file: dv/ring_checker_sva.sv
`timescale 1ns/100ps
`include "pbc_regs.svh"

module ring_checker (
  // Clock, reset, enable
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  // Ring pins
  input wire logic [`NUM_CELLS-1:0] drive_in,
  input wire logic [`NUM_CELLS-1:0] drive_out,
  input wire logic [`NUM_CELLS-1:0] port_skip_n,
  // Recovery and amplitude
  input wire logic                  freq_ref_clock,
  input wire logic                  cdr_locked,
  input wire logic [`AMP_W-1:0]     amp_level_mv,
  input wire logic                  amplitude_ok
);
  logic [5:0] quiet_reg;
  logic [5:0] quiet_next;
  logic       ref_last_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Cycles since the reference last moved; saturates so it never wraps to a false "live"
  assign quiet_next = (freq_ref_clock != ref_last_reg) ? 6'h00 : quiet_reg + {5'h00, quiet_reg != 6'h3F};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_reg    <= 6'h00;
      ref_last_reg <= 1'b0;
    end else if (ce) begin
      quiet_reg    <= quiet_next;
      ref_last_reg <= freq_ref_clock;
    end
  end

  // ----
  // Checks
  // ----
  chk_release_quiet: assert property (
    $rose(rst_n) |-> drive_out == 5'h00 && !cdr_locked && !amplitude_ok) else $error("outputs not clear at release");
  chk_unlocked_silent: assert property (
    (!cdr_locked && ce) |=> !drive_out[1]) else $error("retimer output active while unlocked");
  chk_ce_freeze: assert property (
    !ce |=> $stable(drive_out) && $stable(cdr_locked) && $stable(amplitude_ok)) else $error("outputs moved with ce low");
  chk_amp_high: assert property (
    (ce && $stable(amp_level_mv) && amp_level_mv >= 10'h190) [*6] |-> amplitude_ok) else $error("amplitude flag low");
  chk_amp_low: assert property (
    (ce && $stable(amp_level_mv) && amp_level_mv <= 10'h064) [*6] |-> !amplitude_ok) else $error("amplitude flag high");
  chk_bypass_cell2: assert property (
    (ce && !port_skip_n[2]) [*4] |-> drive_out[3] == drive_out[2]) else $error("cell 2 bypass broken");
  chk_bypass_cell4: assert property (
    (ce && !port_skip_n[4]) [*4] |-> drive_out[0] == drive_out[4]) else $error("ring closure broken");
  chk_inloop_cell2: assert property (
    (ce && port_skip_n[2]) [*6] |-> drive_out[3] == $past(drive_in[2], 3)) else $error("cell 2 return path broken");
  chk_ref_loss_drop: assert property (
    quiet_reg >= 6'h2D |-> !cdr_locked) else $error("lock held without reference");
  chk_lock_ref_live: assert property (
    $rose(cdr_locked) |-> quiet_reg < 6'h0C) else $error("lock gained without reference");

  // Main scenarios reached
  cover property ($rose(cdr_locked));
  cover property ($rose(amplitude_ok));
  cover property ((ce && !port_skip_n[2]) [*4]);
endmodule : ring_checker

// file: dv/cable_far_end.sv
`timescale 1ns/100ps

module cable_far_end (
  // Clock and run controls
  input  wire logic clk,
  input  wire logic ref_run,
  input  wire logic tx_run,
  // Far-side outputs
  output logic      freq_ref_clock,
  output logic      cable_bit
);
  logic [2:0]  div_reg;
  logic [15:0] pat_reg;

  initial begin
    div_reg = 3'h0;
    pat_reg = 16'hD26C;
    freq_ref_clock = 1'b0;
  end

  // Reference at a tenth of the line rate; stands still when stopped
  always @(posedge clk) begin
    if (ref_run) begin
      div_reg <= (div_reg == 3'h4) ? 3'h0 : div_reg + 3'h1;
      freq_ref_clock <= freq_ref_clock ^ (div_reg == 3'h4);
    end
  end

  // Runs of at most two so phase acquisition sees steady edges
  always @(posedge clk) begin
    if (tx_run) begin
      pat_reg <= {pat_reg[14:0], pat_reg[15]};
    end
  end

  assign cable_bit = pat_reg[15];
endmodule : cable_far_end

// file: dv/test_loop_port_bypass_retimer.sv
`timescale 1ns/100ps
`include "pbc_regs.svh"

module test_loop_port_bypass_retimer;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic [4:0]  din;
  logic [4:0]  drive_in;
  logic [4:0]  drive_out;
  logic [4:0]  port_skip_n;
  logic        freq_ref_clock;
  logic        cdr_locked;
  logic [9:0]  amp_level_mv;
  logic        amplitude_ok;
  logic        ref_run;
  logic        tx_run;
  logic        cable_bit;
  logic        ok;
  logic        found;
  logic [31:0] lfsr;
  logic [4:0]  exp_out;
  logic        hist_in[$];
  logic        hist_out[$];
  int          fail_count;
  int          check_count;
  int          cycles;
  logic [9:0]  amp_tab[6] = '{10'h1F4, 10'h0FA, 10'h064, 10'h0FA, 10'h190, 10'h063};
  logic        amp_exp[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Cable sits on cell 0 while the far side transmits
  assign drive_in = tx_run ? {din[4:1], cable_bit} : din;

  loop_port_bypass_retimer u_dut (.clk, .rst_n, .ce, .drive_in, .drive_out, .port_skip_n,
                                  .freq_ref_clock, .cdr_locked, .amp_level_mv, .amplitude_ok);
  cable_far_end u_far (.clk, .ref_run, .tx_run, .freq_ref_clock, .cable_bit);

  // ----
  // Helpers
  // ----
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wait_lock();
    int n;
    n = 0;
    while (cdr_locked !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    check({4'h0, cdr_locked}, 5'h01);
  endtask : wait_lock

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // Ring model while unlocked: retimer feeds cell 1 with zeros
  function automatic logic [4:0] route_model(input int d, input int s);
    int         up;
    logic [4:0] o;
    up = 0;
    for (int k = 1; k < 5; k++) begin
      o[k] = up[0];
      up = ((s >> k) & 1) ? ((d >> k) & 1) : up;
    end
    o[0] = up[0];
    return o;
  endfunction : route_model

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    din = 5'h00;
    port_skip_n = 5'h1F;
    amp_level_mv = 10'h000;
    ref_run = 1'b0;
    tx_run = 1'b0;
    lfsr = 32'h0001_18DA;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Every bypass pattern, random drive bits
    for (int i = 0; i < 40; i++) begin
      lfsr = lfsr_next(lfsr);
      din = lfsr[4:0];
      port_skip_n = i[4:0];
      step(4);
      exp_out = route_model(int'(din), int'(port_skip_n));
      check(drive_out, exp_out);
    end
    // Clock enable low freezes the ring
    ce = 1'b0;
    din = ~din;
    step(5);
    check(drive_out, exp_out);
    ce = 1'b1;
    // Amplitude thresholds, in-between levels hold
    for (int i = 0; i < 6; i++) begin
      amp_level_mv = amp_tab[i];
      step(8);
      check({4'h0, amplitude_ok}, {4'h0, amp_exp[i]});
    end
    // Cable on cell 0, lock, then retimed stream reaches slot A
    port_skip_n = 5'h1F;
    tx_run = 1'b1;
    ref_run = 1'b1;
    wait_lock();
    for (int i = 0; i < 48; i++) begin
      lfsr = lfsr_next(lfsr);
      din[4:1] = lfsr[3:0];
      hist_in.push_back(drive_in[0]);
      hist_out.push_back(drive_out[1]);
      step(1);
    end
    found = 1'b0;
    for (int l = 3; l < 17; l++) begin
      ok = 1'b1;
      for (int j = 20; j < 48; j++) begin
        ok = ok & (hist_out[j] === hist_in[j - l]);
      end
      found = found | ok;
    end
    check({4'h0, found}, 5'h01);
    // Reference lost drops lock and silences slot A; relock follows
    ref_run = 1'b0;
    step(60);
    check({cdr_locked, drive_out[1], 3'h0}, 5'h00);
    ref_run = 1'b1;
    wait_lock();
    // Cable goes quiet: a long run of one level drops lock, edges bring it back
    tx_run = 1'b0;
    step(20);
    check({4'h0, cdr_locked}, 5'h00);
    tx_run = 1'b1;
    wait_lock();
    tally_and_finish();
  end
endmodule : test_loop_port_bypass_retimer

bind loop_port_bypass_retimer ring_checker u_chk (.clk, .rst_n, .ce, .drive_in, .drive_out, .port_skip_n,
                                                  .freq_ref_clock, .cdr_locked, .amp_level_mv, .amplitude_ok);
